// *** hdl/rtw_pkg.sv ***
// constants, field layouts and types of the reset timer and watchdog
package rtw_pkg;

    // ********************************************************************
    // clock and internal rc oscillator rates
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 4;
    // both rc oscillators are modelled as enables at this period
    localparam int RC_TICK_NS    = 40;
    localparam int RC_DIV        = RC_TICK_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 8;

    // ********************************************************************
    // timer periods, as times and as rc ticks
    // ********************************************************************
    localparam int RESET_LONG_MS   = 18;
    localparam int RESET_SHORT_US  = 10;
    localparam int WATCHDOG_MS     = 18;
    localparam int TICK_W          = 24;
    localparam int RESET_LONG_TICKS  = RESET_LONG_MS * 1_000_000 / RC_TICK_NS;
    localparam int RESET_SHORT_TICKS = RESET_SHORT_US * 1_000 / RC_TICK_NS;
    localparam int WATCHDOG_TICKS    = WATCHDOG_MS * 1_000_000 / RC_TICK_NS;
    localparam int POST_W            = 7;

    // ********************************************************************
    // register map
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COMMAND  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CONFIG   = 8'h0c;
    localparam logic [7:0] PRESCALE_RESET = 8'hff;
    localparam logic [7:0] STATUS_RESET   = 8'h18;
    localparam logic [7:0] CONFIG_RESET   = 8'h1b;
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_SLEEP_BIT = 1;

    // timer prescale control layout
    typedef struct packed {
        logic [3:0] otherFields;
        logic       prescalerAssignSelect;
        logic [2:0] prescaleRatioField;
    } rtw_prescale_s;

    // status layout
    typedef struct packed {
        logic       pinChangeWakeFlag;
        logic [1:0] zeroHigh;
        logic       watchdogExpiryFlag;
        logic       sleepEntryFlag;
        logic [2:0] zeroLow;
    } rtw_status_s;

    typedef enum logic [2:0] {
        MODE_LOW_POWER_CRYSTAL  = 3'h0,
        MODE_STANDARD_CRYSTAL   = 3'h1,
        MODE_HIGH_SPEED_CRYSTAL = 3'h2,
        MODE_INTERNAL_RC        = 3'h3,
        MODE_EXTERNAL_RC        = 3'h4,
        MODE_EXTERNAL_CLOCK     = 3'h5
    } rtw_osc_e;

    // configuration layout
    typedef struct packed {
        logic [2:0] zeroHigh;
        logic       externalResetEnable;
        logic       watchdogFuseEnable;
        rtw_osc_e   oscMode;
    } rtw_config_s;

    typedef enum logic [3:0] {
        ST_WAIT_PIN = 4'b0001,
        ST_TIMING   = 4'b0010,
        ST_RUN      = 4'b0100,
        ST_SLEEP    = 4'b1000
    } rtw_state_e;

endpackage

// *** hdl/rtw_tick_div.sv ***
// free-running divider that stands in for an internal rc oscillator
`timescale 1ns/1ns
module rtw_tick_div #(
    parameter logic [rtw_pkg::DIV_W-1:0] DIV = rtw_pkg::DIV_W'(rtw_pkg::RC_DIV)
) (
    input  wire logic clock,
    input  wire logic rst,
    output logic      tick
);

    logic [rtw_pkg::DIV_W-1:0] count;
    wire                       wrap = (count == DIV - 1'b1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= wrap ? '0 : count + 1'b1;
            tick  <= wrap;
        end
    end

endmodule // rtw_tick_div

// *** hdl/rtw_reset_timer_and_watchdog.sv ***
// reset latch, device reset timer and watchdog timer with apb registers
`timescale 1ns/1ns

// Notes on behaviour
// - power-up sets the reset latch and clears the reset timer
// - reset timer counts only once the reset pin is high; expiry ends reset
// - processor held in reset while the reset timer is active
// - reset timer runs from its own rc tick source
// - period long after power-on; later resets long for crystals, else short
// - reset timer runs on every power-up
// - watchdog time-out in sleep also runs the reset timer delay
// - reset sources: power-on, reset pin, watchdog, pin-change wake
// - watchdog counts its own rc ticks, running on during sleep
// - watchdog expiry resets the device in run and wakes it from sleep
// - watchdog reset clears the active-low watchdog expiry flag
// - watchdog disabled when the fuse enable bit is zero
// - base time-out 18 ms; assigned prescaler divides up to 1:128
// - software assigns the prescaler by writing prescale control
// - clear op zeroes watchdog, and prescaler when assigned
// - sleep op zeroes watchdog, and prescaler when assigned
// - reset pin may serve as plain input; then the pin causes no reset
// - sleep entry sets expiry flag, clears sleep flag, stops oscillator
// - flags keep values until next reset; pin pulse leaves them
// - any wake from sleep clears the watchdog counter
module rtw_reset_timer_and_watchdog #(
    parameter logic [rtw_pkg::TICK_W-1:0] RESET_LONG_TICKS =
        rtw_pkg::TICK_W'(rtw_pkg::RESET_LONG_TICKS),
    parameter logic [rtw_pkg::TICK_W-1:0] WATCHDOG_TICKS =
        rtw_pkg::TICK_W'(rtw_pkg::WATCHDOG_TICKS)
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rtw_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       externalResetPin,
    input  wire logic                       pinChangeWake,
    output logic                            cpuReset,
    output logic                            sleeping,
    output logic                            oscDriverOn,
    output logic                            sharedInputPin,
    output logic                            watchdogResetEvent,
    output rtw_pkg::rtw_status_s            status
);

    // ********************************************************************
    // state and registers
    // ********************************************************************
    rtw_pkg::rtw_state_e              state;
    rtw_pkg::rtw_state_e              next_state;
    rtw_pkg::rtw_prescale_s           prescale;
    rtw_pkg::rtw_config_s             deviceCfg;
    logic [2:0]                       pinSync;
    logic                             pinLevel;
    logic                             porPending;
    logic [rtw_pkg::TICK_W-1:0]       timerCount;
    logic [rtw_pkg::TICK_W-1:0]       wdCount;
    logic [rtw_pkg::POST_W-1:0]       postCount;
    logic                             timerTick;
    logic                             wdTick;

    // ********************************************************************
    // rc tick sources
    // ********************************************************************
    rtw_tick_div u_timer_osc (
        .clock (clock),
        .rst   (rst),
        .tick  (timerTick)
    );

    rtw_tick_div u_watchdog_osc (
        .clock (clock),
        .rst   (rst),
        .tick  (wdTick)
    );

    // ********************************************************************
    // reset pin
    // ********************************************************************
    // third stage confirms the second before the level is taken
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinSync  <= 3'h0;
            pinLevel <= 1'b0;
        end else begin
            pinSync <= {pinSync[1:0], externalResetPin};
            if (pinSync[1] == pinSync[2]) begin
                pinLevel <= pinSync[2];
            end
        end
    end

    wire pinResetOn  = deviceCfg.externalResetEnable;
    wire pinAsserted = pinResetOn & ~pinLevel;
    wire pinHigh     = ~pinResetOn | pinLevel;

    // ********************************************************************
    // apb decode
    // ********************************************************************
    wire setupPhase  = psel & ~penable;
    wire accessDone  = psel & penable & pready;
    wire wrDone      = accessDone & pwrite;
    wire selPrescale = (paddr == rtw_pkg::OFF_PRESCALE);
    wire selStatus   = (paddr == rtw_pkg::OFF_STATUS);
    wire selCommand  = (paddr == rtw_pkg::OFF_COMMAND);
    wire selConfig   = (paddr == rtw_pkg::OFF_CONFIG);
    wire mapped      = selPrescale | selStatus | selCommand | selConfig;
    wire [31:0] readMux = selStatus ? {24'h0, status} :
                          selConfig ? {24'h0, deviceCfg} : 32'h0;

    wire inRun    = (state == rtw_pkg::ST_RUN);
    wire inSleep  = (state == rtw_pkg::ST_SLEEP);
    wire inTiming = (state == rtw_pkg::ST_TIMING);
    wire cmdWrite = wrDone & selCommand & inRun;
    wire clearOp  = cmdWrite & pwdata[rtw_pkg::CMD_CLEAR_BIT];
    wire sleepOp  = cmdWrite & pwdata[rtw_pkg::CMD_SLEEP_BIT];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase & ~mapped;
            if (setupPhase) begin
                prdata <= readMux;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale  <= rtw_pkg::PRESCALE_RESET;
            deviceCfg <= rtw_pkg::CONFIG_RESET;
        end else begin
            if (wrDone & selPrescale) begin
                prescale <= pwdata[7:0];
            end
            if (wrDone & selConfig) begin
                deviceCfg <= pwdata[7:0];
            end
        end
    end

    // ********************************************************************
    // device reset timer
    // ********************************************************************
    wire crystalMode =
        (deviceCfg.oscMode == rtw_pkg::MODE_LOW_POWER_CRYSTAL) |
        (deviceCfg.oscMode == rtw_pkg::MODE_STANDARD_CRYSTAL) |
        (deviceCfg.oscMode == rtw_pkg::MODE_HIGH_SPEED_CRYSTAL);
    wire [rtw_pkg::TICK_W-1:0] terminal =
        (porPending | crystalMode) ? RESET_LONG_TICKS :
        rtw_pkg::TICK_W'(rtw_pkg::RESET_SHORT_TICKS);
    wire timerDone = inTiming & timerTick &
                     (timerCount >= terminal - 1'b1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timerCount <= '0;
            porPending <= 1'b1;
        end else begin
            if (!inTiming || pinAsserted) begin
                timerCount <= '0;
            end else if (timerTick) begin
                timerCount <= timerCount + 1'b1;
            end
            if (timerDone) begin
                porPending <= 1'b0;
            end
        end
    end

    // ********************************************************************
    // watchdog and prescaler
    // ********************************************************************
    wire wdRun = deviceCfg.watchdogFuseEnable & (inRun | inSleep);
    wire assigned = prescale.prescalerAssignSelect;
    wire [7:0] ratioSpan = 8'h01 << prescale.prescaleRatioField;
    wire [rtw_pkg::POST_W-1:0] postLast =
        rtw_pkg::POST_W'(ratioSpan - 8'h01);
    wire baseWrap = wdRun & wdTick & (wdCount >= WATCHDOG_TICKS - 1'b1);
    wire timeout  = baseWrap & (~assigned | (postCount >= postLast));
    wire wake     = inSleep & (pinAsserted | timeout | pinChangeWake);
    wire wdClear  = clearOp | sleepOp | wake;
    wire sleepTaken = sleepOp & ~timeout & ~pinAsserted;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wdCount <= '0;
        end else if (!wdRun || wdClear || baseWrap) begin
            wdCount <= '0;
        end else if (wdTick) begin
            wdCount <= wdCount + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            postCount <= '0;
        end else if (!wdRun || (wdClear && assigned) || timeout) begin
            postCount <= '0;
        end else if (baseWrap && assigned) begin
            postCount <= postCount + 1'b1;
        end
    end

    // ********************************************************************
    // sequencer
    // ********************************************************************
    always_comb begin
        next_state = state;
        case (state)
            rtw_pkg::ST_WAIT_PIN: begin
                if (pinHigh) begin
                    next_state = rtw_pkg::ST_TIMING;
                end
            end
            rtw_pkg::ST_TIMING: begin
                if (pinAsserted) begin
                    next_state = rtw_pkg::ST_WAIT_PIN;
                end else if (timerDone) begin
                    next_state = rtw_pkg::ST_RUN;
                end
            end
            rtw_pkg::ST_RUN: begin
                if (pinAsserted) begin
                    next_state = rtw_pkg::ST_WAIT_PIN;
                end else if (timeout) begin
                    next_state = rtw_pkg::ST_TIMING;
                end else if (sleepOp) begin
                    next_state = rtw_pkg::ST_SLEEP;
                end
            end
            rtw_pkg::ST_SLEEP: begin
                if (pinAsserted) begin
                    next_state = rtw_pkg::ST_WAIT_PIN;
                end else if (timeout || pinChangeWake) begin
                    next_state = rtw_pkg::ST_TIMING;
                end
            end
            default: begin
                next_state = rtw_pkg::ST_WAIT_PIN;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= rtw_pkg::ST_WAIT_PIN;
        end else begin
            state <= next_state;
        end
    end

    // ********************************************************************
    // status flags
    // ********************************************************************
    // a pin reset touches none of the flags
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status <= rtw_pkg::STATUS_RESET;
        end else begin
            if (timeout) begin
                status.watchdogExpiryFlag <= 1'b0;
                status.pinChangeWakeFlag  <= 1'b0;
            end else if (sleepTaken) begin
                status.watchdogExpiryFlag <= 1'b1;
                status.sleepEntryFlag     <= 1'b0;
            end else if (inSleep && pinChangeWake && !pinAsserted) begin
                status.pinChangeWakeFlag  <= 1'b1;
                status.watchdogExpiryFlag <= 1'b1;
            end
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    wire nextHeld  = (next_state == rtw_pkg::ST_WAIT_PIN) |
                     (next_state == rtw_pkg::ST_TIMING);
    wire nextSleep = (next_state == rtw_pkg::ST_SLEEP);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpuReset           <= 1'b1;
            sleeping           <= 1'b0;
            oscDriverOn        <= 1'b1;
            sharedInputPin     <= 1'b0;
            watchdogResetEvent <= 1'b0;
        end else begin
            cpuReset           <= nextHeld;
            sleeping           <= nextSleep;
            oscDriverOn        <= ~nextSleep;
            sharedInputPin     <= ~pinResetOn & pinLevel;
            watchdogResetEvent <= timeout;
        end
    end

endmodule // rtw_reset_timer_and_watchdog

// *** verification/rtw_props.sv ***
// port assertions for the reset timer and watchdog
`timescale 1ns/1ns
module rtw_props #(
    parameter logic [rtw_pkg::TICK_W-1:0] RESET_LONG_TICKS = 24'h000014,
    parameter logic [rtw_pkg::TICK_W-1:0] WATCHDOG_TICKS   = 24'h00001e
) (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 cpuReset,
    input wire logic                 sleeping,
    input wire logic                 oscDriverOn,
    input wire logic                 watchdogResetEvent,
    input wire rtw_pkg::rtw_status_s status
);
    // ********************************************************************
    // cycles spent in and out of processor reset
    // ********************************************************************
    logic [31:0] hiCnt;
    logic [31:0] runCnt;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hiCnt  <= '0;
            runCnt <= '0;
        end else begin
            hiCnt  <= cpuReset ? hiCnt + 32'h1 : '0;
            runCnt <= cpuReset ? '0 : runCnt + 32'h1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // ********************************************************************
    // assertions
    // ********************************************************************
    a_reset_width: assert property ($fell(cpuReset) |->
        hiCnt >= 32'((RESET_LONG_TICKS - 1) * rtw_pkg::RC_DIV))
        else $error("processor reset ended too early");
    a_dog_period: assert property (watchdogResetEvent |->
        runCnt >= 32'((WATCHDOG_TICKS - 1) * rtw_pkg::RC_DIV))
        else $error("watchdog expired too early");
    a_dog_resets: assert property (watchdogResetEvent |-> ##[0:2] cpuReset)
        else $error("watchdog expiry gave no reset");
    a_expiry_flag: assert property (watchdogResetEvent |-> ##[0:2]
        (!status.watchdogExpiryFlag && !status.pinChangeWakeFlag))
        else $error("expiry flag not cleared");
    a_event_pulse: assert property (watchdogResetEvent |=> !watchdogResetEvent)
        else $error("watchdog event longer than one cycle");
    a_sleep_osc: assert property (sleeping |-> !oscDriverOn)
        else $error("oscillator driver on in sleep");
    a_sleep_flags: assert property ($rose(sleeping) |-> ##[0:1]
        (status.watchdogExpiryFlag && !status.sleepEntryFlag))
        else $error("sleep entry flags wrong");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    c_dog: cover property (watchdogResetEvent);
    c_sleep: cover property ($rose(sleeping));
    c_error: cover property (pslverr);
endmodule // rtw_props

bind rtw_reset_timer_and_watchdog rtw_props #(
    .RESET_LONG_TICKS(RESET_LONG_TICKS),
    .WATCHDOG_TICKS(WATCHDOG_TICKS)
) props_u (.clock, .rst, .psel, .penable, .pready, .pslverr, .cpuReset,
    .sleeping, .oscDriverOn, .watchdogResetEvent, .status);

// *** verification/rtw_board_model.sv ***
// board circuitry driving the active-low external reset pin
`timescale 1ns/1ns
module rtw_board_model #(
    parameter int HOLD_CYCLES  = 50,
    parameter int PULSE_CYCLES = 20
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pulseReq,
    output logic      externalResetPin
);
    int lowCnt;

    // released pin is pulled up, so it reads high
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            lowCnt           <= HOLD_CYCLES;
            externalResetPin <= 1'b0;
        end else if (pulseReq) begin
            lowCnt           <= PULSE_CYCLES;
            externalResetPin <= 1'b0;
        end else if (lowCnt > 0) begin
            lowCnt <= lowCnt - 1;
        end else begin
            externalResetPin <= 1'b1;
        end
    end
endmodule // rtw_board_model

// *** verification/rtw_reset_timer_and_watchdog_tb.sv ***
// self-checking bench of the reset timer and watchdog
`timescale 1ns/1ns
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    errors++; $display("CHECK FAILED %s expected %h seen %h", what, exp, \
    got); end end
module rtw_reset_timer_and_watchdog_tb;
    typedef struct packed {
        logic        rd;
        logic        err;
        logic [31:0] data;
    } rtw_note_s;
    localparam logic [23:0] LONG = 24'h000014;
    localparam logic [23:0] DOG  = 24'h00001e;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        pinChangeWake = 0, pulseReq = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, lfsr = 32'hef09, prdata;
    logic        pready, pslverr, externalResetPin, cpuReset, sleeping;
    logic        oscDriverOn, sharedInputPin, watchdogResetEvent;
    rtw_pkg::rtw_status_s status;
    rtw_note_s   notes[$];
    int          errors = 0, n_checks = 0, cycles = 0, events = 0, e0;
    logic        ratio;
    logic [2:0]  mode;

    rtw_reset_timer_and_watchdog #(.RESET_LONG_TICKS(LONG),
        .WATCHDOG_TICKS(DOG)) dut_u (.clock, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .externalResetPin, .pinChangeWake, .cpuReset, .sleeping,
        .oscDriverOn, .sharedInputPin, .watchdogResetEvent, .status);
    rtw_board_model board_u (.clock, .rst, .pulseReq, .externalResetPin);

    always #2 clock = ~clock;

    // ********************************************************************
    // tasks
    // ********************************************************************
    function automatic logic [23:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[23:0];
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // unused upper data bits carry random values
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [31:0] exp);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {rnd(), d};
        notes.push_back('{!w, a > 8'h0c, exp});
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic waitFor(input string what, ref logic s, input logic v,
                           input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            @(posedge clock);
            k++;
        end
        `CHK(what, v, s)
    endtask

    task automatic pinPulse();
        pulseReq <= 1'b1;
        @(posedge clock);
        pulseReq <= 1'b0;
    endtask

    // ********************************************************************
    // monitor and timeout
    // ********************************************************************
    always @(posedge clock) begin : mon
        rtw_note_s n;
        cycles++;
        if (cycles == 40000) begin
            errors++;
            end_of_test();
        end else begin
            if (watchdogResetEvent === 1'b1) events++;
            if (psel && penable && pready === 1'b1) begin
                n = notes.pop_front();
                `CHK("pslverr", n.err, pslverr)
                if (n.rd) `CHK("prdata", n.data, prdata)
            end
        end
    end

    // ********************************************************************
    // scenarios
    // ********************************************************************
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK("cpuReset", 1'b1, cpuReset)
        apb(0, 8'h00, 0, 0);
        apb(0, 8'h04, 0, 8'h18);
        apb(0, 8'h0c, 0, 8'h1b);
        apb(0, 8'h10, 0, 0);
        repeat (215) @(posedge clock);
        `CHK("cpuReset", 1'b1, cpuReset)
        waitFor("cpuReset", cpuReset, 0, 100);
        $display("power-up test done");
        apb(1, 8'h00, 0, 0);
        e0 = events;
        repeat (4) begin
            repeat (200) @(posedge clock);
            apb(1, 8'h08, 8'h01, 0);
        end
        `CHK("events", e0, events)
        waitFor("event", watchdogResetEvent, 1, 400);
        waitFor("cpuReset", cpuReset, 1, 4);
        repeat (1000) @(posedge clock);
        `CHK("cpuReset", 1'b1, cpuReset)
        waitFor("cpuReset", cpuReset, 0, 2000);
        apb(0, 8'h04, 0, 8'h08);
        $display("watchdog run test done");
        apb(1, 8'h00, 0, 0);
        apb(1, 8'h08, 8'h02, 0);
        apb(0, 8'h04, 0, 8'h10);
        `CHK("oscDriverOn", 1'b0, oscDriverOn)
        e0 = events;
        repeat (250) @(posedge clock);
        `CHK("events", e0, events)
        `CHK("sleeping", 1'b1, sleeping)
        waitFor("event", watchdogResetEvent, 1, 400);
        waitFor("cpuReset", cpuReset, 1, 4);
        waitFor("cpuReset", cpuReset, 0, 3000);
        apb(0, 8'h04, 0, 8'h00);
        $display("watchdog sleep test done");
        apb(1, 8'h08, 8'h02, 0);
        pinChangeWake <= 1'b1;
        @(posedge clock);
        pinChangeWake <= 1'b0;
        waitFor("cpuReset", cpuReset, 1, 4);
        waitFor("cpuReset", cpuReset, 0, 3000);
        apb(0, 8'h04, 0, 8'h90);
        pinPulse();
        waitFor("cpuReset", cpuReset, 1, 30);
        waitFor("cpuReset", cpuReset, 0, 3000);
        apb(0, 8'h04, 0, 8'h90);
        $display("wake and pin test done");
        ratio = 1'(rnd() & 24'h1);
        apb(1, 8'h00, {4'h0, 1'b1, 2'b00, ratio}, 0);
        apb(1, 8'h08, 8'h01, 0);
        e0 = events;
        repeat ((300 << ratio) - 30) @(posedge clock);
        `CHK("events", e0, events)
        waitFor("event", watchdogResetEvent, 1, 80);
        waitFor("cpuReset", cpuReset, 1, 4);
        waitFor("cpuReset", cpuReset, 0, 3000);
        $display("prescaler test done");
        apb(1, 8'h00, 0, 0);
        apb(1, 8'h0c, 8'h13, 0);
        apb(0, 8'h0c, 0, 8'h13);
        e0 = events;
        repeat (700) @(posedge clock);
        `CHK("events", e0, events)
        apb(1, 8'h0c, 8'h11, 0);
        pinPulse();
        waitFor("cpuReset", cpuReset, 1, 30);
        waitFor("cpuReset", cpuReset, 0, 400);
        // random oscillator mode: crystals give the long period, others short
        mode = 3'(rnd() % 6);
        apb(1, 8'h0c, {5'h02, mode}, 0);
        pinPulse();
        waitFor("cpuReset", cpuReset, 1, 30);
        repeat (300) @(posedge clock);
        `CHK("cpuReset", mode > 3'h2, cpuReset)
        waitFor("cpuReset", cpuReset, 0, 3000);
        apb(1, 8'h0c, 8'h03, 0);
        pinPulse();
        repeat (10) @(posedge clock);
        `CHK("cpuReset", 1'b0, cpuReset)
        `CHK("sharedInputPin", 1'b0, sharedInputPin)
        repeat (20) @(posedge clock);
        `CHK("sharedInputPin", 1'b1, sharedInputPin)
        $display("fuse and pin mode test done");
        end_of_test();
    end
endmodule // rtw_reset_timer_and_watchdog_tb
